/* rtl/eic_consts.svh */
`ifndef EIC_CONSTS_SVH
`define EIC_CONSTS_SVH

// channel count and register geometry
`define EIC_NUM_CH      4
`define EIC_ADDR_W      32
`define EIC_DATA_W      8

// register byte addresses
`define EIC_ADDR_FLAG   32'hE01FC140
`define EIC_ADDR_WAKE   32'hE01FC144
`define EIC_ADDR_SENSE  32'hE01FC148
`define EIC_ADDR_POLAR  32'hE01FC14C

// field layout: channel bits sit in [3:0], [7:4] reserved
`define EIC_FIELD_LSB   0
`define EIC_FIELD_MSB   3

// reset values
`define EIC_RST_FLAG    4'h0
`define EIC_RST_WAKE    4'h0
`define EIC_RST_SENSE   4'h0
`define EIC_RST_POLAR   4'h0
`define EIC_RST_RDATA   8'h00

// sense select encodings
`define EIC_SENSE_LEVEL 1'b0
`define EIC_SENSE_EDGE  1'b1

// pin synchroniser depth before the agree stage
`define EIC_SYNC_STAGES 3

`endif

/* rtl/eic_pkg.sv */
`include "eic_consts.svh"

package eic_pkg;

    typedef logic [`EIC_NUM_CH-1:0] eic_ch_t;

    typedef struct packed {
        logic [`EIC_ADDR_W-1:0] addr;
        logic [`EIC_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } eic_bus_t;

endpackage

/* rtl/eic_sync.sv */
`timescale 1ns/1ps
`include "eic_consts.svh"

module eic_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    if (W < 1) begin : g_bad_w
        $error("eic_sync: W must be at least 1");
    end

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    // a bit changes only once stages two and three agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q  <= '0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q  <= next_q;
        end
    end

endmodule

/* rtl/eic_top.sv */
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "eic_consts.svh"

module eic_top #(
    parameter int PINS = 3
) (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire eic_pkg::eic_bus_t            bus,
    output logic      [`EIC_DATA_W-1:0]       rd_data,
    input  wire logic [`EIC_NUM_CH*PINS-1:0]  pin_state,
    input  wire logic [`EIC_NUM_CH*PINS-1:0]  pin_sel,
    output eic_pkg::eic_ch_t                  irq_flag,
    output logic                              wake_req
);

    localparam int NCH = `EIC_NUM_CH;
    localparam int NP  = NCH * PINS;

    if (PINS < 1 || PINS > 8) begin : g_bad_pins
        $error("eic_top: PINS must lie in 1..8");
    end

    ////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic addr_hit(
        input logic [`EIC_ADDR_W-1:0] addr,
        input logic [`EIC_ADDR_W-1:0] target
    );
        return addr == target;
    endfunction

    // merge the selected pins of one channel
    function automatic logic combine(
        input logic [PINS-1:0] st,
        input logic [PINS-1:0] sel,
        input logic            sense,
        input logic            pol
    );
        logic r;
        logic found;
        r     = ~pol;
        found = 1'b0;
        if (sense == `EIC_SENSE_EDGE) begin
            for (int i = 0; i < PINS; i++) begin
                if (sel[i] && !found) begin
                    r     = st[i];
                    found = 1'b1;
                end
            end
        end else if (!pol) begin
            for (int i = 0; i < PINS; i++) begin
                if (sel[i]) begin
                    r = r & st[i];
                end
            end
        end else begin
            for (int i = 0; i < PINS; i++) begin
                if (sel[i]) begin
                    r = r | st[i];
                end
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser

    logic [NP-1:0] pin_sync;

    eic_sync #(
        .W (NP)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   (pin_state),
        .q   (pin_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // registers and request merge

    eic_pkg::eic_ch_t irq_polarity_reg;
    eic_pkg::eic_ch_t irq_sense_select;
    eic_pkg::eic_ch_t irq_wake_enable;
    eic_pkg::eic_ch_t combined_request;
    eic_pkg::eic_ch_t prev_request;
    eic_pkg::eic_ch_t active;
    eic_pkg::eic_ch_t prev_active;
    eic_pkg::eic_ch_t edge_hit;
    eic_pkg::eic_ch_t set_ev;
    eic_pkg::eic_ch_t clr;

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        always_comb begin
            combined_request[c] = combine(
                pin_sync[c*PINS +: PINS],
                pin_sel[c*PINS +: PINS],
                irq_sense_select[c],
                irq_polarity_reg[c]);
        end
    end

    // active when the merged level matches the polarity
    always_comb begin
        active      = ~(combined_request ^ irq_polarity_reg);
        prev_active = ~(prev_request ^ irq_polarity_reg);
        edge_hit    = active & ~prev_active;
        set_ev      = (irq_sense_select & edge_hit)
                    | (~irq_sense_select & active);
    end

    ////////////////////////////////////////////////////////////////////////
    // register file

    eic_pkg::eic_ch_t          next_polarity;
    eic_pkg::eic_ch_t          next_sense;
    eic_pkg::eic_ch_t          next_wake_en;
    eic_pkg::eic_ch_t          next_flag;
    logic                      next_wake_req;
    logic [`EIC_DATA_W-1:0]    next_rd_data;

    always_comb begin
        next_polarity = irq_polarity_reg;
        next_sense    = irq_sense_select;
        next_wake_en  = irq_wake_enable;
        clr           = '0;
        if (bus.wr) begin
            // reserved bits 7:4 are dropped on write
            if (addr_hit(bus.addr, `EIC_ADDR_POLAR)) begin
                next_polarity =
                    bus.wdata[`EIC_FIELD_MSB:`EIC_FIELD_LSB];
            end
            if (addr_hit(bus.addr, `EIC_ADDR_SENSE)) begin
                next_sense =
                    bus.wdata[`EIC_FIELD_MSB:`EIC_FIELD_LSB];
            end
            if (addr_hit(bus.addr, `EIC_ADDR_WAKE)) begin
                next_wake_en =
                    bus.wdata[`EIC_FIELD_MSB:`EIC_FIELD_LSB];
            end
            if (addr_hit(bus.addr, `EIC_ADDR_FLAG)) begin
                clr = bus.wdata[`EIC_FIELD_MSB:`EIC_FIELD_LSB];
            end
        end
        // a new event wins over a same-cycle clear
        next_flag     = (irq_flag & ~clr) | set_ev;
        next_wake_req = |(irq_wake_enable & set_ev);
    end

    // unmapped addresses and reserved bits read zero
    always_comb begin
        next_rd_data = `EIC_RST_RDATA;
        if (bus.rd) begin
            if (addr_hit(bus.addr, `EIC_ADDR_FLAG)) begin
                next_rd_data = {4'h0, irq_flag};
            end else if (addr_hit(bus.addr, `EIC_ADDR_WAKE)) begin
                next_rd_data = {4'h0, irq_wake_enable};
            end else if (addr_hit(bus.addr, `EIC_ADDR_SENSE)) begin
                next_rd_data = {4'h0, irq_sense_select};
            end else if (addr_hit(bus.addr, `EIC_ADDR_POLAR)) begin
                next_rd_data = {4'h0, irq_polarity_reg};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_polarity_reg <= `EIC_RST_POLAR;
            irq_sense_select <= `EIC_RST_SENSE;
            irq_wake_enable  <= `EIC_RST_WAKE;
            irq_flag         <= `EIC_RST_FLAG;
            prev_request     <= '1;
            wake_req         <= 1'b0;
            rd_data          <= `EIC_RST_RDATA;
        end else begin
            irq_polarity_reg <= next_polarity;
            irq_sense_select <= next_sense;
            irq_wake_enable  <= next_wake_en;
            irq_flag         <= next_flag;
            prev_request     <= combined_request;
            wake_req         <= next_wake_req;
            rd_data          <= next_rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic rst_d;
    always_ff @(posedge clk) begin
        rst_d <= rst;
    end

    property p_polar_reset;
        rst_d |-> irq_polarity_reg == 4'h0;
    endproperty
    a_polar_reset: assert property (p_polar_reset)
        else $error("polarity not zero after reset");

    property p_sense_reset;
        rst_d |-> irq_sense_select == 4'h0 && irq_flag == 4'h0;
    endproperty
    a_sense_reset: assert property (p_sense_reset)
        else $error("sense or flag not zero after reset");

    property p_reserved_zero;
        bus.rd |=> rd_data[7:4] == 4'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved read bits not zero");

    property p_sync_follows;
        $stable(pin_state)[*6] |-> pin_sync == pin_state;
    endproperty
    a_sync_follows: assert property (p_sync_follows)
        else $error("synchronised pins do not follow inputs");

    // per-bit view, since routed-away pins never sit still
    for (genvar b = 0; b < NP; b++) begin : g_sync_chk
        property p_sync_bit;
            @(posedge clk) disable iff (rst)
            $stable(pin_state[b])[*6] |-> pin_sync[b] == pin_state[b];
        endproperty
        a_sync_bit: assert property (p_sync_bit)
            else $error("synchronised pin does not follow its input");
    end

    property p_unselected;
        pin_sel[PINS-1:0] == '0 |->
            combined_request[0] == ~irq_polarity_reg[0];
    endproperty
    a_unselected: assert property (p_unselected)
        else $error("unselected pins drive the request");

    property p_level_and;
        !irq_sense_select[0] && !irq_polarity_reg[0] |->
            combined_request[0] ==
            &(pin_sync[PINS-1:0] | ~pin_sel[PINS-1:0]);
    endproperty
    a_level_and: assert property (p_level_and)
        else $error("active-low level merge is not an AND");

    property p_level_or;
        !irq_sense_select[0] && irq_polarity_reg[0] |->
            combined_request[0] ==
            |(pin_sync[PINS-1:0] & pin_sel[PINS-1:0]);
    endproperty
    a_level_or: assert property (p_level_or)
        else $error("active-high level merge is not an OR");

    property p_edge_lowest;
        irq_sense_select[0] && pin_sel[0] |->
            combined_request[0] == pin_sync[0];
    endproperty
    a_edge_lowest: assert property (p_edge_lowest)
        else $error("edge mode did not take the lowest pin");

    property p_edge_sets;
        irq_sense_select[0] && irq_polarity_reg[0]
            && $stable(irq_polarity_reg[0])
            && $rose(combined_request[0]) |=> irq_flag[0];
    endproperty
    a_edge_sets: assert property (p_edge_sets)
        else $error("rising edge did not set the flag");

    property p_level_holds;
        !irq_sense_select[0] && active[0] |=> irq_flag[0];
    endproperty
    a_level_holds: assert property (p_level_holds)
        else $error("flag dropped while level active");

    property p_clear;
        bus.wr && bus.addr == `EIC_ADDR_FLAG && bus.wdata[0]
            && !set_ev[0] |=> !irq_flag[0];
    endproperty
    a_clear: assert property (p_clear)
        else $error("write of one did not clear the flag");

    property p_wake;
        irq_wake_enable[0] && set_ev[0] |=> wake_req;
    endproperty
    a_wake: assert property (p_wake)
        else $error("enabled request did not raise wake");

    property p_no_wake;
        irq_wake_enable == 4'h0 |=> !wake_req;
    endproperty
    a_no_wake: assert property (p_no_wake)
        else $error("wake raised with all wake enables off");

endmodule

/* verification/eic_pin_model.sv */
`timescale 1ns/1ps

module eic_pin_model #(
    parameter int PINS = 3
) (
    input  wire logic              clk,
    input  wire logic [4*PINS-1:0] want_st,
    input  wire logic [4*PINS-1:0] want_sel,
    output logic      [4*PINS-1:0] pin_state,
    output logic      [4*PINS-1:0] pin_sel
);

    initial begin
        pin_state = '0;
        pin_sel   = '0;
    end

    // pins routed elsewhere wander every cycle, so they must be ignored
    always @(posedge clk) begin
        pin_sel   <= want_sel;
        pin_state <= (want_st & want_sel) | (~want_sel & ~pin_state);
    end

endmodule

/* verification/ext_irq_input_conditioning_tb.sv */
`timescale 1ns/1ps
`include "eic_consts.svh"

module ext_irq_input_conditioning_tb;

    localparam int P = 3;

    logic              clk       = 1'b0;
    logic              rst       = 1'b1;
    eic_pkg::eic_bus_t bus       = '0;
    logic [4*P-1:0]    want_st   = '0;
    logic [4*P-1:0]    want_sel  = '0;
    logic [4*P-1:0]    pin_state;
    logic [4*P-1:0]    pin_sel;
    logic [7:0]        rd_data;
    eic_pkg::eic_ch_t  irq_flag;
    logic              wake_req;
    int                n_errors  = 0;
    int                cmp_count = 0;
    int                wake_cnt  = 0;

    always #50 clk = ~clk;

    always @(posedge clk) begin
        if (wake_req === 1'b1) begin
            wake_cnt <= wake_cnt + 1;
        end
    end

    eic_top #(.PINS(P)) uut (
        .clk       (clk),
        .rst       (rst),
        .bus       (bus),
        .rd_data   (rd_data),
        .pin_state (pin_state),
        .pin_sel   (pin_sel),
        .irq_flag  (irq_flag),
        .wake_req  (wake_req)
    );

    eic_pin_model #(.PINS(P)) pins (
        .clk       (clk),
        .want_st   (want_st),
        .want_sel  (want_sel),
        .pin_state (pin_state),
        .pin_sel   (pin_sel)
    );

    ////////////////////////////////////////////////////////////////////////

    task automatic end_sim;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge clk);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge clk);
        bus.wr    <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clk);
        bus.rd   <= 1'b0;
        #1;
        chk(rd_data, exp);
    endtask

    // level request: active-low is an AND gate, active-high an OR gate
    function automatic logic lvl_act(input logic [P-1:0] st,
                                     input logic [P-1:0] sel,
                                     input logic         pol);
        if (pol) begin
            return |(st & sel);
        end
        return (sel != '0) && !(&(st | ~sel));
    endfunction

    // edge request follows the lowest selected pin only
    function automatic logic low_pin(input logic [P-1:0] st,
                                     input logic [P-1:0] sel);
        return |(st & sel & (~sel + 1'b1));
    endfunction

    // edge channels keep only their lowest selected pin
    function automatic logic [4*P-1:0] one_pin(input logic [4*P-1:0] sel,
                                               input logic [3:0]     sense);
        logic [4*P-1:0] r;
        r = sel;
        for (int c = 0; c < 4; c++) begin
            if (sense[c]) begin
                r[c*P +: P] = sel[c*P +: P] & (~sel[c*P +: P] + 1'b1);
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////

    initial begin
        #1000000;
        n_errors++;
        end_sim;
    end

    initial begin
        logic [3:0]     sense;
        logic [3:0]     pol;
        logic [3:0]     wake;
        logic [3:0]     f1;
        logic [3:0]     f2;
        logic [4*P-1:0] old_st;
        int             w0;
        logic [4*P-1:0] src;
        void'($urandom(32'h4A00));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(`EIC_ADDR_FLAG, 8'h00);
        rd(`EIC_ADDR_WAKE, 8'h00);
        rd(`EIC_ADDR_SENSE, 8'h00);
        rd(`EIC_ADDR_POLAR, 8'h00);
        wr(32'hE01FC150, 8'hFF);
        rd(32'hE01FC150, 8'h00);
        for (int it = 0; it < 60; it++) begin
            sense = 4'($urandom);
            pol   = 4'($urandom);
            wake  = 4'($urandom);
            wr(`EIC_ADDR_SENSE, {4'h0, sense});
            wr(`EIC_ADDR_POLAR, {4'h0, pol});
            wr(`EIC_ADDR_WAKE, {4'h0, wake});
            rd(`EIC_ADDR_POLAR, {4'h0, pol});
            @(posedge clk);
            if (it[0]) begin
                want_sel <= (4*P)'($urandom);
            end else begin
                want_sel <= one_pin((4*P)'($urandom), sense);
            end
            want_st  <= (4*P)'($urandom);
            repeat (10) @(posedge clk);
            wr(`EIC_ADDR_FLAG, 8'h0F);
            repeat (2) @(posedge clk);
            for (int c = 0; c < 4; c++) begin
                f1[c] = !sense[c] && lvl_act(want_st[c*P +: P],
                                             want_sel[c*P +: P], pol[c]);
            end
            rd(`EIC_ADDR_FLAG, {4'h0, f1});
            chk({7'h00, wake_req}, {7'h00, |(wake & f1)});
            @(posedge clk);
            old_st = want_st;
            w0     = wake_cnt;
            want_st <= (4*P)'($urandom);
            repeat (10) @(posedge clk);
            for (int c = 0; c < 4; c++) begin
                if (sense[c]) begin
                    f2[c] = low_pin(old_st[c*P +: P], want_sel[c*P +: P])
                         != low_pin(want_st[c*P +: P], want_sel[c*P +: P])
                         && low_pin(want_st[c*P +: P], want_sel[c*P +: P])
                         == pol[c];
                end else begin
                    f2[c] = f1[c] || lvl_act(want_st[c*P +: P],
                                             want_sel[c*P +: P], pol[c]);
                end
            end
            rd(`EIC_ADDR_FLAG, {4'h0, f2});
            chk({4'h0, irq_flag}, {4'h0, f2});
            chk({7'h00, wake_cnt != w0}, {7'h00, |(wake & f2)});
            // pin model check: selected pins carry the wanted states
            src = (pin_state & pin_sel) ^ (want_st & want_sel);
            chk({7'h00, src != '0}, 8'h00);
        end
        // every pin selected and held, then parked before a mid-run reset
        @(posedge clk);
        want_sel <= '1;
        repeat (12) @(posedge clk);
        want_sel <= '0;
        repeat (4) @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(`EIC_ADDR_FLAG, 8'h00);
        rd(`EIC_ADDR_WAKE, 8'h00);
        rd(`EIC_ADDR_SENSE, 8'h00);
        rd(`EIC_ADDR_POLAR, 8'h00);
        chk({7'h00, wake_req}, 8'h00);
        end_sim;
    end

endmodule
